// *** rtl/psm_pkg.sv ***
// Constants of the packet stream thread mapper: port numbering, connection matrix,
// register map and field layout. Assumes a 12-bit register window behind AXI4-Lite.
package psm_pkg;
    localparam int NUM_SRC = 16;
    localparam int NUM_DST = 16;
    localparam int NUM_THREAD = 64;
    localparam int THREAD_W = 6;
    localparam int DATA_W = 32;
    localparam int DEST_W = 4;
    localparam int ADDR_W = 12;
    // Transmit (source) port numbering
    localparam logic [3:0] SRC_DMA_G = 4'h0;
    localparam logic [3:0] SRC_DMA_L = 4'h1;
    localparam logic [3:0] SRC_GBE = 4'h2;
    localparam logic [3:0] SRC_REASM = 4'hE;
    // Receive (destination) port numbering
    localparam logic [3:0] DST_DMA_G = 4'h0;
    localparam logic [3:0] DST_DMA_L = 4'h1;
    localparam logic [3:0] DST_GBE = 4'h2;
    localparam logic [3:0] DST_ING0 = 4'h3;
    localparam logic [3:0] DST_POST = 4'h8;
    localparam logic [3:0] DST_EG0 = 4'h9;
    localparam logic [3:0] DST_REASM = 4'hC;
    localparam logic [3:0] DST_SA1 = 4'hD;
    localparam logic [3:0] DST_STATS = 4'hF;
    // Allowed destinations per source, row of 16 bits per source, source 15 first
    localparam logic [255:0] CONN_MATRIX = {
        16'h0001, 16'h0FFB, 16'h77FF, 16'h7BFF, 16'h7DFF, 16'h7EFF, 16'h7F7F, 16'h7FBF,
        16'h7FDF, 16'h7FEF, 16'h7FF7, 16'h0003, 16'h0003, 16'h0FFB, 16'h7FFC, 16'hFFFE};
    // Mapper target codes
    localparam logic [3:0] MAP_CODE_MAX = 4'hA;
    localparam logic [3:0] MAP_CODE_ING0 = 4'h2;
    localparam logic [3:0] MAP_FIELD_RST = 4'h0;
    localparam int MAP_FIELD_W = 8;
    // DMA transmit thread allocation
    localparam logic [5:0] DMA_TH_ING0 = 6'h08;
    localparam logic [5:0] DMA_TH_POST = 6'h0D;
    localparam logic [5:0] DMA_TH_EG0 = 6'h0E;
    localparam logic [5:0] DMA_TH_REASM = 6'h11;
    localparam logic [5:0] DMA_TH_SA1 = 6'h12;
    localparam logic [5:0] DMA_TH_STATS = 6'h14;
    localparam logic [5:0] REASM_OUT_THREADS = 6'h20;
    localparam int GBE_PRIOS = 8;
    // Register offsets
    localparam logic [11:0] MAP_BASE = 12'h500;
    localparam logic [11:0] MAP_LAST = 12'h53C;
    localparam logic [11:0] CTRL_OFFS = 12'h600;
    localparam logic [11:0] INT_STAT_OFFS = 12'h604;
    localparam logic [11:0] INT_MASK_OFFS = 12'h608;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] INT_MASK_RST = 4'h0;
    // Control bits
    localparam int CTRL_PWR = 0;
    localparam int CTRL_PA = 1;
    localparam int CTRL_SA = 2;
    localparam int CTRL_GBE = 3;
    // Interrupt bits
    localparam int INT_ROUTE_ERR = 0;
    localparam int INT_GBE = 1;
    localparam int INT_PA = 2;
    localparam int INT_MAP_REJ = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [2:0] {SEL_NONE, SEL_MAP, SEL_CTRL, SEL_STAT, SEL_MASK} psm_sel_t;
endpackage

// *** rtl/psm_switch.sv ***
// Packet streaming switch with Ethernet thread mapper, power/clock control and
// interrupt merge. Assumes sources hold valid, dest, thread and data until src_ready.
//
// Notes on behaviour
// (R01) Ethernet source thread equals port times eight plus priority, 64 threads.
// (R02) Each Ethernet thread goes to one target from its mapper code.
// (R03) Ethernet threads sent to a DMA keep their thread number.
// (R04) Mapper writes of 11 or more leave that field unchanged.
// (R05) Each mapper word holds four byte fields, low byte lowest thread.
// (R06) All mapper fields reset to zero, the global DMA.
// (R07) Only transfers in the fixed connection matrix pass; others are dropped.
// (R08) DMA transmit thread number selects the destination component.
// (R09) Reassembly takes from ingress 0 and 3, returns to ingress 1 and 4.
// (R10) Reassembly accepts 64 input threads and emits only 32 threads.
// (R11) Software routes accelerator traffic through the local DMA.
// (R12) Software brings up power, clocks, queues, DMA, then mapper and engines.
// (R13) Software initialises packet accelerator before security accelerator.
// (R14) One power domain, off after reset, switched as a whole.
// (R15) Accelerator and switch clocks gate apart; packet clock runs if others used.
// (R16) Several interrupt sources merge into one line.
// (R17) Sixteen mapper words at four-byte stride from the printed offset.
`timescale 1ns/1ps
`default_nettype none
module psm_switch (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] src_valid,
    output logic [15:0] src_ready,
    input wire logic [63:0] src_dest,
    input wire logic [95:0] src_thread,
    input wire logic [511:0] src_data,
    input wire logic [15:0] src_last,
    output logic [15:0] dst_valid,
    input wire logic [15:0] dst_ready,
    output logic [5:0] dst_thread,
    output logic [31:0] dst_data,
    output logic dst_last,
    input wire logic gbe_irq,
    input wire logic pa_irq,
    output logic irq,
    output logic power_on,
    output logic pa_clk_en,
    output logic sa_clk_en,
    output logic gbe_clk_en
);
    typedef enum logic [1:0] {SW_IDLE, SW_GRANT, SW_HOLD} psm_state_t;

    function automatic psm_pkg::psm_sel_t psm_decode(input logic [11:0] a);
        if (a >= psm_pkg::MAP_BASE && a <= psm_pkg::MAP_LAST) begin
            return psm_pkg::SEL_MAP;
        end else if (a == psm_pkg::CTRL_OFFS) begin
            return psm_pkg::SEL_CTRL;
        end else if (a == psm_pkg::INT_STAT_OFFS) begin
            return psm_pkg::SEL_STAT;
        end else if (a == psm_pkg::INT_MASK_OFFS) begin
            return psm_pkg::SEL_MASK;
        end else begin
            return psm_pkg::SEL_NONE;
        end
    endfunction

    // Round robin pick, searching upward from the port after the last winner
    function automatic logic [3:0] psm_pick(input logic [15:0] req, input logic [3:0] last);
        logic [3:0] idx;
        logic [3:0] res;
        res = last;
        for (int k = 16; k >= 1; k--) begin
            idx = last + k[3:0];
            if (req[idx]) begin
                res = idx;
            end
        end
        return res;
    endfunction

    // AXI4-Lite slave state
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_got_reg, w_got_reg;
    logic [11:0] wr_addr_reg;
    logic [31:0] wr_data_reg, rdata_reg;
    logic [3:0] wr_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [3:0] map_reg [64];
    logic [3:0] ctrl_reg, int_stat_reg, int_mask_reg;
    logic irq_reg, power_on_reg, pa_clk_en_reg, sa_clk_en_reg, gbe_clk_en_reg;

    wire aw_hs = s_axi_awvalid & awready_reg;
    wire w_hs = s_axi_wvalid & wready_reg;
    wire ar_hs = s_axi_arvalid & arready_reg;
    wire do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
    wire aw_got_next = (aw_got_reg | aw_hs) & ~do_write;
    wire w_got_next = (w_got_reg | w_hs) & ~do_write;
    wire bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
    wire rvalid_next = ar_hs | (rvalid_reg & ~s_axi_rready);
    psm_pkg::psm_sel_t wr_sel, rd_sel;
    assign wr_sel = psm_decode(wr_addr_reg);
    assign rd_sel = psm_decode(s_axi_araddr);
    wire [3:0] wr_word = wr_addr_reg[5:2];
    wire [3:0] rd_word = s_axi_araddr[5:2];
    wire map_wr = do_write & (wr_sel == psm_pkg::SEL_MAP);
    wire ctrl_wr = do_write & (wr_sel == psm_pkg::SEL_CTRL);
    wire stat_wr = do_write & (wr_sel == psm_pkg::SEL_STAT);
    wire mask_wr = do_write & (wr_sel == psm_pkg::SEL_MASK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= psm_pkg::RESP_OKAY;
            wr_addr_reg <= 12'h000;
            wr_data_reg <= 32'h00000000;
            wr_strb_reg <= 4'h0;
        end else begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awready_reg <= ~aw_got_next & ~bvalid_next;
            wready_reg <= ~w_got_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
            if (aw_hs) begin
                wr_addr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                wr_data_reg <= s_axi_wdata;
                wr_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                bresp_reg <= (wr_sel == psm_pkg::SEL_NONE) ? psm_pkg::RESP_DECERR : psm_pkg::RESP_OKAY;
            end
        end
    end

    // Read path; mapper fields read back zero-extended to their byte
    logic [31:0] rd_value;
    always_comb begin
        rd_value = 32'h00000000;
        if (rd_sel == psm_pkg::SEL_MAP) begin
            for (int b = 0; b < 4; b++) begin
                rd_value[b*psm_pkg::MAP_FIELD_W +: 4] = map_reg[{rd_word, b[1:0]}];
            end
        end else if (rd_sel == psm_pkg::SEL_CTRL) begin
            rd_value[3:0] = ctrl_reg;
        end else if (rd_sel == psm_pkg::SEL_STAT) begin
            rd_value[3:0] = int_stat_reg;
        end else if (rd_sel == psm_pkg::SEL_MASK) begin
            rd_value[3:0] = int_mask_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= psm_pkg::RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next & ~ar_hs;
            rvalid_reg <= rvalid_next;
            if (ar_hs) begin
                rdata_reg <= rd_value;
                rresp_reg <= (rd_sel == psm_pkg::SEL_NONE) ? psm_pkg::RESP_DECERR : psm_pkg::RESP_OKAY;
            end
        end
    end

    // Mapper fields; byte strobes select fields, illegal codes are dropped
    logic [63:0] map_rej;
    genvar gi;
    generate
        for (gi = 0; gi < psm_pkg::NUM_THREAD; gi++) begin : g_map
            localparam int BYTE = gi % 4;
            wire [7:0] wval = wr_data_reg[BYTE*psm_pkg::MAP_FIELD_W +: psm_pkg::MAP_FIELD_W];
            // (R17) Word select stride
            wire hit = map_wr & (wr_word == 4'(gi / 4)) & wr_strb_reg[BYTE];
            // (R04) Illegal code check
            wire legal = (wval <= {4'h0, psm_pkg::MAP_CODE_MAX});
            assign map_rej[gi] = hit & ~legal;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    // (R06) Reset to global DMA
                    map_reg[gi] <= psm_pkg::MAP_FIELD_RST;
                end else if (hit && legal) begin
                    // (R05) Byte field store
                    map_reg[gi] <= wval[3:0];
                end
            end
        end
    endgenerate

    // Switch datapath
    psm_state_t state_reg, state_next;
    logic [3:0] win_reg, win_next;
    logic [15:0] src_ready_reg, dst_valid_reg;
    logic [5:0] out_thread_reg;
    logic [31:0] out_data_reg;
    logic out_last_reg;
    logic [3:0] out_dest_reg;

    // (R14) No new grant while powered down; (R15) switch lives on the packet clock
    wire switch_run = ctrl_reg[psm_pkg::CTRL_PWR] & pa_clk_en_reg;
    wire [5:0] w_thread = src_thread[win_reg*6 +: 6];
    wire [3:0] w_code = map_reg[w_thread];

    // (R08) DMA thread to destination
    logic [3:0] dma_dest;
    logic dma_ok;
    always_comb begin
        dma_ok = 1'b1;
        if (w_thread < psm_pkg::DMA_TH_ING0) begin
            dma_dest = psm_pkg::DST_GBE;
        end else if (w_thread < psm_pkg::DMA_TH_POST) begin
            dma_dest = 4'(w_thread - psm_pkg::DMA_TH_ING0) + psm_pkg::DST_ING0;
        end else if (w_thread == psm_pkg::DMA_TH_POST) begin
            dma_dest = psm_pkg::DST_POST;
        end else if (w_thread < psm_pkg::DMA_TH_REASM) begin
            dma_dest = 4'(w_thread - psm_pkg::DMA_TH_EG0) + psm_pkg::DST_EG0;
        end else if (w_thread == psm_pkg::DMA_TH_REASM) begin
            dma_dest = psm_pkg::DST_REASM;
        end else if (w_thread < psm_pkg::DMA_TH_STATS) begin
            dma_dest = 4'(w_thread - psm_pkg::DMA_TH_SA1) + psm_pkg::DST_SA1;
        end else begin
            dma_dest = psm_pkg::DST_STATS;
            dma_ok = (w_thread == psm_pkg::DMA_TH_STATS);
        end
    end

    // (R02) Mapper code to target; codes 2 and up skip the Ethernet receive slot
    wire [3:0] gbe_dest = (w_code < psm_pkg::MAP_CODE_ING0) ? w_code : w_code + 4'h1;
    wire is_dma = (win_reg == psm_pkg::SRC_DMA_G) | (win_reg == psm_pkg::SRC_DMA_L);
    wire [3:0] w_dest = is_dma ? dma_dest :
                        (win_reg == psm_pkg::SRC_GBE) ? gbe_dest : src_dest[win_reg*4 +: 4];
    // (R10) Reassembly output limited to 32 threads
    wire reasm_ok = (win_reg != psm_pkg::SRC_REASM) | (w_thread < psm_pkg::REASM_OUT_THREADS);
    // (R07) Connection matrix check; (R09) reassembly paths are rows of it
    wire conn_ok = psm_pkg::CONN_MATRIX[{win_reg, w_dest}];
    wire route_ok = conn_ok & reasm_ok & (~is_dma | dma_ok);
    wire route_err = (state_reg == SW_GRANT) & ~route_ok;
    wire out_take = (state_reg == SW_HOLD) & dst_ready[out_dest_reg];

    always_comb begin
        state_next = state_reg;
        win_next = win_reg;
        case (state_reg)
            SW_IDLE: begin
                if (switch_run && (src_valid != 16'h0000)) begin
                    win_next = psm_pick(src_valid, win_reg);
                    state_next = SW_GRANT;
                end
            end
            SW_GRANT: begin
                state_next = route_ok ? SW_HOLD : SW_IDLE;
            end
            SW_HOLD: begin
                if (out_take) begin
                    state_next = SW_IDLE;
                end
            end
            default: begin
                state_next = SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= SW_IDLE;
            win_reg <= 4'hF;
            src_ready_reg <= 16'h0000;
            dst_valid_reg <= 16'h0000;
            out_thread_reg <= 6'h00;
            out_data_reg <= 32'h00000000;
            out_last_reg <= 1'b0;
            out_dest_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            win_reg <= win_next;
            src_ready_reg <= (state_next == SW_GRANT) ? (16'h0001 << win_next) : 16'h0000;
            if (state_reg == SW_GRANT && route_ok) begin
                // (R03) Thread number passes unchanged; (R01) it holds port and priority
                out_thread_reg <= w_thread;
                out_data_reg <= src_data[win_reg*32 +: 32];
                out_last_reg <= src_last[win_reg];
                out_dest_reg <= w_dest;
                dst_valid_reg <= 16'h0001 << w_dest;
            end else if (out_take) begin
                dst_valid_reg <= 16'h0000;
            end
        end
    end

    // Control, power and clock enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= psm_pkg::CTRL_RST;
            int_mask_reg <= psm_pkg::INT_MASK_RST;
            int_stat_reg <= 4'h0;
            irq_reg <= 1'b0;
            power_on_reg <= 1'b0;
            pa_clk_en_reg <= 1'b0;
            sa_clk_en_reg <= 1'b0;
            gbe_clk_en_reg <= 1'b0;
        end else begin
            if (ctrl_wr && wr_strb_reg[0]) begin
                ctrl_reg <= wr_data_reg[3:0];
            end
            if (mask_wr && wr_strb_reg[0]) begin
                int_mask_reg <= wr_data_reg[3:0];
            end
            // Set wins over a same-cycle write-one clear
            int_stat_reg <= (int_stat_reg & ~((stat_wr && wr_strb_reg[0]) ? wr_data_reg[3:0] : 4'h0))
                            | {(|map_rej), pa_irq, gbe_irq, route_err};
            // (R16) Merge onto one line
            irq_reg <= |(int_stat_reg & int_mask_reg);
            // (R14) Whole domain switches together
            power_on_reg <= ctrl_reg[psm_pkg::CTRL_PWR];
            // (R15) Packet clock forced on when either other domain runs
            pa_clk_en_reg <= ctrl_reg[psm_pkg::CTRL_PWR] & (ctrl_reg[psm_pkg::CTRL_PA]
                             | ctrl_reg[psm_pkg::CTRL_SA] | ctrl_reg[psm_pkg::CTRL_GBE]);
            sa_clk_en_reg <= ctrl_reg[psm_pkg::CTRL_PWR] & ctrl_reg[psm_pkg::CTRL_SA];
            gbe_clk_en_reg <= ctrl_reg[psm_pkg::CTRL_PWR] & ctrl_reg[psm_pkg::CTRL_GBE];
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign src_ready = src_ready_reg;
    assign dst_valid = dst_valid_reg;
    assign dst_thread = out_thread_reg;
    assign dst_data = out_data_reg;
    assign dst_last = out_last_reg;
    assign irq = irq_reg;
    assign power_on = power_on_reg;
    assign pa_clk_en = pa_clk_en_reg;
    assign sa_clk_en = sa_clk_en_reg;
    assign gbe_clk_en = gbe_clk_en_reg;
endmodule // psm_switch
`default_nettype wire

// *** test/psm_chk.sv ***
// Assertions on psm_switch ports: grants, routing, holding and gating.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/1ps
`default_nettype none
module psm_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] src_valid,
    input wire logic [15:0] src_ready,
    input wire logic [95:0] src_thread,
    input wire logic [511:0] src_data,
    input wire logic [15:0] dst_valid,
    input wire logic [15:0] dst_ready,
    input wire logic [5:0] dst_thread,
    input wire logic [31:0] dst_data,
    input wire logic power_on,
    input wire logic pa_clk_en,
    input wire logic sa_clk_en,
    input wire logic gbe_clk_en
);
    logic [15:0] tk;
    logic [15:0] dma_exp;
    assign tk = src_valid & src_ready;
    // Host priorities share one port, every later thread counts up from ingress 0
    assign dma_exp = (src_thread[5:0] < 6'h08) ? 16'h0004 : 16'h0001 << (src_thread[5:0] - 6'h05);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_src_onehot: assert property ($onehot0(src_ready))
        else $error("several sources granted at once");
    a_dst_onehot: assert property ($onehot0(dst_valid))
        else $error("beat offered to several ports");
    a_dst_hold: assert property (|(dst_valid & ~dst_ready) |=>
        dst_valid == $past(dst_valid) && $stable(dst_data) && $stable(dst_thread))
        else $error("beat dropped before ready");
    a_gbe_thread: assert property (tk[2] |=> dst_valid[1:0] == 2'h0 ||
        dst_thread == $past(src_thread[17:12]))
        else $error("switch thread renumbered toward dma");
    a_dma_fwd: assert property (tk[0] && src_thread[5:0] <= 6'h14 |=>
        dst_valid == $past(dma_exp) && dst_data == $past(src_data[31:0]))
        else $error("dma thread sent to wrong port");
    a_dma_drop: assert property (tk[0] && src_thread[5:0] > 6'h14 |=> dst_valid == 16'h0000)
        else $error("unknown dma thread forwarded");
    a_stats_dest: assert property (tk[15] |=> dst_valid[15:1] == 15'h0000)
        else $error("stats beat left for non global dma");
    a_sec_dest: assert property (tk[3] || tk[4] |=> dst_valid[15:2] == 14'h0000)
        else $error("security beat left for non dma");
    a_reasm_threads: assert property (tk[14] && src_thread[89:84] >= 6'h20 |=> dst_valid == 16'h0000)
        else $error("reassembly thread above 31 forwarded");
    a_grant_clock: assert property (|src_ready |-> power_on && pa_clk_en)
        else $error("grant while packet clock off");
    a_gate_power: assert property (sa_clk_en || gbe_clk_en |-> power_on && pa_clk_en)
        else $error("clock enabled without power or packet clock");
endmodule // psm_chk
bind psm_switch psm_chk u_chk (.*);
`default_nettype wire

// *** test/psm_sink.sv ***
// Far-side receivers of all sixteen destination ports.
// Assumes the switch holds each beat until ready; slow mode waits three cycles.
`timescale 1ns/1ps
`default_nettype none
module psm_sink (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic [15:0] dst_valid,
    output logic [15:0] dst_ready
);
    logic [1:0] cnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || !(|dst_valid)) begin
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end
    assign dst_ready = (!slow || cnt_reg == 2'h3) ? 16'hFFFF : 16'h0000;
endmodule // psm_sink
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for psm_switch: registers, gating, routing, interrupts.
// Assumes psm_sink answers every port; the bench drives all sources.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, gbe_irq = 1'b0, pa_irq = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, dst_data;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] src_valid = 16'h0, src_last = 16'h0, src_ready, dst_valid, dst_ready;
    logic [63:0] src_dest = 64'h0;
    logic [95:0] src_thread = 96'h0;
    logic [511:0] src_data = 512'h0;
    logic [5:0] dst_thread;
    logic dst_last, irq, power_on, pa_clk_en, sa_clk_en, gbe_clk_en;
    int fails = 0, num_checks = 0;
    always #25 aclk = ~aclk;
    psm_switch DUT (.*);
    psm_sink u_sink (.aclk, .aresetn, .slow, .dst_valid, .dst_ready);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        int n;
        @(posedge aclk);
        {aw, w, b, n} = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b && n < 40) begin
            @(posedge aclk);
            n++;
            if (s_axi_awready && !aw) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                b = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        chk("bresp", {b, r}, {1'b1, er});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic t;
        int n;
        @(posedge aclk);
        {t, n} = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!t && n < 40) begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            t = s_axi_rvalid;
        end
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", {t, s_axi_rresp}, {1'b1, er});
        s_axi_rready <= 1'b0;
    endtask
    // ep: port expected, -1 taken and dropped, -2 never taken
    task automatic send(input int i, input logic [3:0] de, input logic [5:0] th, input int ep);
        logic [31:0] d;
        logic g;
        int n;
        d = 32'hC0DE0000 + 32'(i * 64) + 32'(th);
        @(posedge aclk);
        {g, n} = 0;
        src_valid[i] <= 1'b1;
        src_dest[4*i +: 4] <= de;
        src_thread[6*i +: 6] <= th;
        src_data[32*i +: 32] <= d;
        src_last[i] <= th[0];
        while (!g && n < 12) begin
            @(posedge aclk);
            n++;
            g = src_ready[i];
        end
        chk("grant", g, ep > -2);
        src_valid[i] <= 1'b0;
        src_data[32*i +: 32] <= ~d;
        {g, n} = 0;
        while (!g && n < 8) begin
            @(posedge aclk);
            n++;
            g = |(dst_valid & dst_ready);
        end
        chk("deliver", g, ep >= 0);
        if (g) begin
            chk("port", dst_valid, 32'h1 << ep);
            chk("data", dst_data, d);
            chk("last", dst_last, th[0]);
            if (ep < 2) chk("thread", dst_thread, th);
        end
    endtask
    task automatic t_reset();
        rd(12'h500, 32'h0, 2'h0);
        rd(12'h53C, 32'h0, 2'h0);
        rd(12'h540, 32'h0, 2'h3);
        send(0, 4'h0, 6'h08, -2);
        chk("power", {power_on, pa_clk_en, sa_clk_en, gbe_clk_en}, 4'h0);
        $display("test reset done");
    endtask
    task automatic t_power();
        logic [3:0] cv [6] = '{4'h1, 4'h3, 4'h5, 4'h9, 4'hE, 4'hF};
        logic [3:0] ev [6] = '{4'h8, 4'hC, 4'hE, 4'hD, 4'h0, 4'hF};
        // power and clocks before mapper, packet clock first
        for (int k = 0; k < 6; k++) begin
            wr(12'h600, {28'h0, cv[k]}, 4'h1, 2'h0);
            repeat (2) @(posedge aclk);
            chk("enables", {power_on, pa_clk_en, sa_clk_en, gbe_clk_en}, ev[k]);
        end
        $display("test power done");
    endtask
    task automatic t_map();
        wr(12'h504, 32'h0A090801, 4'hF, 2'h0);
        rd(12'h504, 32'h0A090801, 2'h0);
        wr(12'h504, 32'h0B05FF03, 4'hF, 2'h0);
        rd(12'h504, 32'h0A050803, 2'h0);
        rd(12'h604, 32'h8, 2'h0);
        wr(12'h604, 32'h8, 4'h1, 2'h0);
        wr(12'h7F0, 32'h1, 4'hF, 2'h3);
        $display("test map done");
    endtask
    task automatic t_route();
        int t;
        for (int c = 0; c < 11; c++) begin
            t = c * 6;
            slow <= c[0];
            wr(12'(12'h500 + (t / 4) * 4), 32'(c) << (8 * (t % 4)), 4'h1 << (t % 4), 2'h0);
            send(2, 4'h0, 6'(t), c < 2 ? c : c + 1);
        end
        $display("test route done");
    endtask
    task automatic t_dma();
        for (int th = 0; th < 23; th++) begin
            slow <= th[1];
            send(th % 2, 4'h0, 6'(th), th > 20 ? -1 : (th < 8 ? 2 : th - 5));
        end
        $display("test dma done");
    endtask
    task automatic t_matrix();
        int m [12][4] = '{'{3, 0, 0, 0}, '{4, 1, 0, 1}, '{3, 5, 0, -1}, '{15, 0, 0, 0},
            '{15, 1, 0, -1}, '{5, 3, 0, -1}, '{5, 12, 0, 12}, '{14, 4, 31, 4},
            '{14, 7, 0, 7}, '{14, 2, 0, -1}, '{14, 4, 32, -1}, '{10, 15, 0, -1}};
        for (int k = 0; k < 12; k++) begin
            send(m[k][0], 4'(m[k][1]), 6'(m[k][2]), m[k][3]);
        end
        rd(12'h604, 32'h1, 2'h0);
        $display("test matrix done");
    endtask
    task automatic t_irq();
        wr(12'h604, 32'h1, 4'h1, 2'h0);
        gbe_irq <= 1'b1;
        @(posedge aclk);
        gbe_irq <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("irq masked", irq, 1'b0);
        wr(12'h608, 32'h6, 4'h1, 2'h0);
        repeat (2) @(posedge aclk);
        chk("irq", irq, 1'b1);
        rd(12'h604, 32'h2, 2'h0);
        pa_irq <= 1'b1;
        @(posedge aclk);
        pa_irq <= 1'b0;
        wr(12'h604, 32'h2, 4'h1, 2'h0);
        rd(12'h604, 32'h4, 2'h0);
        chk("irq second", irq, 1'b1);
        wr(12'h604, 32'h4, 4'h1, 2'h0);
        repeat (2) @(posedge aclk);
        chk("irq clear", irq, 1'b0);
        $display("test irq done");
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_power();
        t_map();
        t_route();
        t_dma();
        t_matrix();
        t_irq();
        end_sim();
    end
    // Whole run needs about 500 cycles
    initial begin
        #1000000;
        fails++;
        end_sim();
    end
endmodule // testbench
`default_nettype wire
